// ===== verilog/pea_cfg.svh
// Behaviour
// R1 - Energy read returns accumulator plus sample count
// R2 - Input sample averages four AC line cycles
// R3 - Output sample averages a 50 ms window
// R4 - Input update every four AC cycles, below 100 ms
// R5 - Output update every nominal 50 ms
// R6 - Direct format, coefficients m=1, R=0, b=0
// R7 - Energy reads are block reads with PEC
// R8 - Accumulator wraps above 15-bit 7FFFh
// R9 - Sample count rises by one per sample
// R10 - Host divides accumulator by count, polls fast
// R11 - Accumulator, wraps and count snapshot together
// R12 - Accumulator reported as two bytes
// R13 - Sample count is three-byte unsigned
// R14 - Wrap counter is one byte, FFh to 00h
// R15 - Readings live while powered; standby output zero
// R16 - Host polls between 100 ms and 1 s
// R17 - Payload: count 6, acc, wraps, count, PEC
// R18 - Reset clears all channel state
`ifndef PEA_CFG_SVH
`define PEA_CFG_SVH
`define PEA_CLK_MHZ        100
`define PEA_OUT_WIN_MS     50
`define PEA_IN_MAX_WIN_MS  100
`define PEA_AC_PER_WIN     2'd3
`define PEA_WIN_W          24
`define PEA_SUBS_LOG2      4
`define PEA_SUBS_NUM       5'd16
`define PEA_ACC_W          15
`define PEA_WRAP_W         8
`define PEA_CNT_W          24
`define PEA_CMD_EIN        8'h86
`define PEA_CMD_EOUT       8'h87
`define PEA_CMD_COEF       8'h30
`define PEA_EN_COUNT       8'h06
`define PEA_CO_COUNT       8'h05
`define PEA_COEF_M         16'h0001
`define PEA_COEF_B         16'h0000
`define PEA_COEF_R         8'h00
`define PEA_EN_LEN         3'd7
`define PEA_CO_LEN         3'd6
`define PEA_CRC_POLY       8'h07
`endif

// ===== verilog/pea_pkg.sv
package pea_pkg;
    typedef logic [7:0] pea_byte_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_SEND = 3'b100
    } pea_rd_state_type;
endpackage : pea_pkg

// ===== verilog/pea_chan_if.sv
`timescale 1ns/1ps
`include "pea_cfg.svh"
interface pea_chan_if;
    logic                    windowEnd;   // Window closes, add one sample
    logic [`PEA_WIN_W-1:0]   interval;    // Cycles between sub-samples
    logic [`PEA_ACC_W-1:0]   sample;      // Instantaneous power
    logic                    snapReq;     // Capture snapshot
    logic [`PEA_ACC_W-1:0]   snapPaccum;  // Snapshot accumulator
    logic [`PEA_WRAP_W-1:0]  snapWraps;   // Snapshot wrap count
    logic [`PEA_CNT_W-1:0]   snapCount;   // Snapshot sample count
    modport ctrl (output windowEnd, interval, sample, snapReq, input snapPaccum, snapWraps, snapCount);
    modport chan (input windowEnd, interval, sample, snapReq, output snapPaccum, snapWraps, snapCount);
endinterface : pea_chan_if

// ===== verilog/pea_channel.sv
`timescale 1ns/1ps
`include "pea_cfg.svh"
module pea_channel (
    input  wire logic  clock,  // System clock
    input  wire logic  nrst,   // Async reset, active low
    pea_chan_if.chan   bus     // Window control and snapshot
);
    import pea_pkg::*;
    logic [`PEA_WIN_W-1:0]                subCnt_r, subCnt_nxt;
    logic [4:0]                           taken_r, taken_nxt;
    logic [`PEA_ACC_W+`PEA_SUBS_LOG2-1:0] subSum_r, subSum_nxt;
    logic [`PEA_ACC_W-1:0]                paccum_r, paccum_nxt, psample;
    logic [`PEA_WRAP_W-1:0]               wraps_r, wraps_nxt;
    logic [`PEA_CNT_W-1:0]                count_r, count_nxt;
    logic [`PEA_ACC_W-1:0]                snapP_r, snapP_nxt;
    logic [`PEA_WRAP_W-1:0]               snapW_r, snapW_nxt;
    logic [`PEA_CNT_W-1:0]                snapC_r, snapC_nxt;
    logic [`PEA_ACC_W:0]                  sum;

    // Sub-sampling, averaging and accumulation
    always_comb begin
        subCnt_nxt = subCnt_r + 1'b1;
        taken_nxt  = taken_r;
        subSum_nxt = subSum_r;
        paccum_nxt = paccum_r;
        wraps_nxt  = wraps_r;
        count_nxt  = count_r;
        psample    = subSum_r[`PEA_ACC_W+`PEA_SUBS_LOG2-1:`PEA_SUBS_LOG2];  // Mean of 16 points, see R2 see R3
        sum        = {1'b0, paccum_r} + {1'b0, psample};
        if (bus.windowEnd) begin
            subCnt_nxt = '0;
            taken_nxt  = '0;
            subSum_nxt = '0;
            paccum_nxt = sum[`PEA_ACC_W-1:0];                  // Keep low 15 bits, see R8
            if (sum[`PEA_ACC_W])
                wraps_nxt = wraps_r + 1'b1;                    // FFh rolls to 00h, see R14
            count_nxt = count_r + 1'b1;                        // see R9 see R13
        end else if ((taken_r == '0 || subCnt_r >= bus.interval) && taken_r < `PEA_SUBS_NUM) begin
            subCnt_nxt = {{(`PEA_WIN_W-1){1'b0}}, 1'b1};      // First point at window start, then every interval
            taken_nxt  = taken_r + 1'b1;
            subSum_nxt = subSum_r + {{`PEA_SUBS_LOG2{1'b0}}, bus.sample};
        end
    end

    // Snapshot takes all three next values at once
    always_comb begin
        snapP_nxt = snapP_r;
        snapW_nxt = snapW_r;
        snapC_nxt = snapC_r;
        if (bus.snapReq) begin
            snapP_nxt = paccum_nxt;                            // see R11
            snapW_nxt = wraps_nxt;
            snapC_nxt = count_nxt;
        end
    end

    // State registers, cleared on reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            subCnt_r <= '0;                                    // see R18
            taken_r  <= '0;
            subSum_r <= '0;
            paccum_r <= '0;
            wraps_r  <= '0;
            count_r  <= '0;
            snapP_r  <= '0;
            snapW_r  <= '0;
            snapC_r  <= '0;
        end else begin
            subCnt_r <= subCnt_nxt;
            taken_r  <= taken_nxt;
            subSum_r <= subSum_nxt;
            paccum_r <= paccum_nxt;
            wraps_r  <= wraps_nxt;
            count_r  <= count_nxt;
            snapP_r  <= snapP_nxt;
            snapW_r  <= snapW_nxt;
            snapC_r  <= snapC_nxt;
        end
    end

    assign bus.snapPaccum = snapP_r;
    assign bus.snapWraps  = snapW_r;
    assign bus.snapCount  = snapC_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_count_step: assert property (bus.windowEnd |=> count_r == $past(count_r) + 1'b1) // see R9
        else $error("sample count did not step by one");
    a_count_hold: assert property (!bus.windowEnd |=> count_r == $past(count_r))
        else $error("sample count moved without a sample");
    a_wrap_step: assert property (bus.windowEnd && sum[`PEA_ACC_W] |=> wraps_r == $past(wraps_r) + 1'b1) // see R14
        else $error("wrap counter missed an overflow");
    a_snap_atomic: assert property (bus.snapReq |=> snapC_r == count_r && snapP_r == paccum_r && snapW_r == wraps_r) // see R11
        else $error("snapshot fields not captured together");
endmodule : pea_channel

// ===== verilog/pea_accumulator.sv
`timescale 1ns/1ps
`include "pea_cfg.svh"
module pea_accumulator #(
    parameter int        OUT_WIN_CYC = `PEA_OUT_WIN_MS * `PEA_CLK_MHZ * 1000,
    parameter int        IN_MAX_CYC  = `PEA_IN_MAX_WIN_MS * `PEA_CLK_MHZ * 1000,
    parameter logic [6:0] DEV_ADDR   = 7'h10   // Arbitrary bus address
) (
    input  wire logic                    clock,       // 100 MHz clock
    input  wire logic                    nrst,        // Async reset, active low
    input  wire logic                    acZeroCross, // AC line cycle pulse, pin
    input  wire logic                    standby,     // Main output off, pin
    input  wire logic [`PEA_ACC_W-1:0]   inPower,     // Instantaneous input power
    input  wire logic [`PEA_ACC_W-1:0]   outPower,    // Instantaneous output power
    input  wire logic                    rdStart,     // Read command pulse
    input  wire pea_pkg::pea_byte_type   rdCmd,       // Command code
    input  wire logic                    txReady,     // Byte taken by bus shifter
    output logic [7:0]                   txByte,      // Byte to send
    output logic                         txValid,     // Byte valid
    output logic                         txLast,      // Byte is the PEC
    output logic                         rdRefused    // Unknown command pulse
);
    import pea_pkg::*;

    localparam logic [`PEA_WIN_W-1:0] OUT_LAST = `PEA_WIN_W'(OUT_WIN_CYC - 1);
    localparam logic [`PEA_WIN_W-1:0] IN_LAST  = `PEA_WIN_W'(IN_MAX_CYC - 2);
    localparam logic [`PEA_WIN_W-1:0] OUT_IVL  = `PEA_WIN_W'(OUT_WIN_CYC >> `PEA_SUBS_LOG2);
    localparam logic [15:0]           COEF_M   = `PEA_COEF_M;  // Named so its bytes can be selected
    localparam logic [15:0]           COEF_B   = `PEA_COEF_B;

    // Pin synchronisers
    logic acS1_r, acS2_r, acS3_r, stS1_r, stS2_r;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acS1_r <= 1'b0;
            acS2_r <= 1'b0;
            acS3_r <= 1'b0;
            stS1_r <= 1'b0;
            stS2_r <= 1'b0;
        end else begin
            acS1_r <= acZeroCross;
            acS2_r <= acS1_r;
            acS3_r <= acS2_r;
            stS1_r <= standby;
            stS2_r <= stS1_r;
        end
    end
    logic acEdge;
    assign acEdge = acS2_r & ~acS3_r;

    // Window timing for both channels
    logic [1:0]            acCnt_r, acCnt_nxt;
    logic [`PEA_WIN_W-1:0] inCyc_r, inCyc_nxt, inLen_r, inLen_nxt;
    logic [`PEA_WIN_W-1:0] outCyc_r, outCyc_nxt;
    logic                  inEnd, outEnd;
    always_comb begin
        inEnd      = (acEdge && acCnt_r == `PEA_AC_PER_WIN) || inCyc_r == IN_LAST;  // see R4
        outEnd     = outCyc_r == OUT_LAST;                                          // see R5
        acCnt_nxt  = acEdge ? acCnt_r + 1'b1 : acCnt_r;
        inCyc_nxt  = inCyc_r + 1'b1;
        inLen_nxt  = inLen_r;
        outCyc_nxt = outEnd ? '0 : outCyc_r + 1'b1;
        if (inEnd) begin
            acCnt_nxt = '0;
            inCyc_nxt = '0;
            inLen_nxt = inCyc_r + 1'b1;     // Spreads next window's points, see R2
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acCnt_r  <= '0;
            inCyc_r  <= '0;
            inLen_r  <= '0;
            outCyc_r <= '0;
        end else begin
            acCnt_r  <= acCnt_nxt;
            inCyc_r  <= inCyc_nxt;
            inLen_r  <= inLen_nxt;
            outCyc_r <= outCyc_nxt;
        end
    end

    // Read engine state
    pea_rd_state_type      state_r, state_nxt;
    logic                  chSel_r, chSel_nxt;
    logic [2:0]            idx_r, idx_nxt, len_r, len_nxt;
    pea_byte_type          cmd_r, cmd_nxt, crc_r, crc_nxt;
    pea_byte_type          buf_r [7];
    pea_byte_type          buf_nxt [7];
    logic [7:0]            txByte_r, txByte_nxt;
    logic                  txValid_r, txValid_nxt, txLast_r, txLast_nxt, refused_r, refused_nxt;
    logic                  snapReq [2];
    logic                  winEnd [2];
    logic [`PEA_WIN_W-1:0] ivl [2];
    logic [`PEA_ACC_W-1:0] smp [2];
    logic [`PEA_ACC_W-1:0] sPaccum [2];
    logic [`PEA_WRAP_W-1:0] sWraps [2];
    logic [`PEA_CNT_W-1:0]  sCount [2];
    logic [2:0]            idxInc;
    logic                  isEnergy;

    assign winEnd[0] = inEnd;
    assign winEnd[1] = outEnd;
    assign ivl[0]    = inLen_r >> `PEA_SUBS_LOG2;
    assign ivl[1]    = OUT_IVL;
    assign smp[0]    = inPower;
    assign smp[1]    = stS2_r ? '0 : outPower;  // Output off reads zero, see R15

    // One accumulator channel each for input and output
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            pea_chan_if chIf ();
            assign chIf.windowEnd = winEnd[g];
            assign chIf.interval  = ivl[g];
            assign chIf.sample    = smp[g];
            assign chIf.snapReq   = snapReq[g];
            assign sPaccum[g]     = chIf.snapPaccum;
            assign sWraps[g]      = chIf.snapWraps;
            assign sCount[g]      = chIf.snapCount;
            pea_channel u_chan (
                .clock (clock),
                .nrst  (nrst),
                .bus   (chIf.chan)
            );
        end
    endgenerate

    // CRC-8 step for the packet error code
    function automatic pea_byte_type crc8(input pea_byte_type c, input pea_byte_type d);
        pea_byte_type r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ `PEA_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc8

    // Read sequencing: snapshot, load payload, stream bytes, then PEC
    always_comb begin
        state_nxt   = state_r;
        chSel_nxt   = chSel_r;
        idx_nxt     = idx_r;
        len_nxt     = len_r;
        cmd_nxt     = cmd_r;
        crc_nxt     = crc_r;
        buf_nxt     = buf_r;
        txByte_nxt  = txByte_r;
        txValid_nxt = txValid_r;
        txLast_nxt  = txLast_r;
        refused_nxt = 1'b0;
        snapReq[0]  = 1'b0;
        snapReq[1]  = 1'b0;
        idxInc      = idx_r + 1'b1;
        isEnergy    = rdCmd == `PEA_CMD_EIN || rdCmd == `PEA_CMD_EOUT;
        case (state_r)
            ST_IDLE: begin
                if (rdStart) begin
                    if (isEnergy || rdCmd == `PEA_CMD_COEF) begin
                        cmd_nxt   = rdCmd;
                        chSel_nxt = rdCmd == `PEA_CMD_EOUT;
                        snapReq[0] = rdCmd == `PEA_CMD_EIN;   // see R11
                        snapReq[1] = rdCmd == `PEA_CMD_EOUT;
                        state_nxt = ST_LOAD;
                    end else begin
                        refused_nxt = 1'b1;
                    end
                end
            end
            ST_LOAD: begin
                if (cmd_r == `PEA_CMD_COEF) begin
                    buf_nxt[0] = `PEA_CO_COUNT;                // see R6
                    buf_nxt[1] = COEF_M[7:0];
                    buf_nxt[2] = COEF_M[15:8];
                    buf_nxt[3] = COEF_B[7:0];
                    buf_nxt[4] = COEF_B[15:8];
                    buf_nxt[5] = `PEA_COEF_R;
                    buf_nxt[6] = 8'h00;
                    len_nxt    = `PEA_CO_LEN;
                end else begin
                    buf_nxt[0] = `PEA_EN_COUNT;                // see R17 see R1
                    buf_nxt[1] = sPaccum[chSel_r][7:0];        // see R12
                    buf_nxt[2] = {1'b0, sPaccum[chSel_r][14:8]};
                    buf_nxt[3] = sWraps[chSel_r];
                    buf_nxt[4] = sCount[chSel_r][7:0];         // see R13
                    buf_nxt[5] = sCount[chSel_r][15:8];
                    buf_nxt[6] = sCount[chSel_r][23:16];
                    len_nxt    = `PEA_EN_LEN;
                end
                crc_nxt     = crc8(crc8(crc8(8'h00, {DEV_ADDR, 1'b0}), cmd_r), {DEV_ADDR, 1'b1}); // see R7
                idx_nxt     = '0;
                txByte_nxt  = buf_nxt[0];
                txValid_nxt = 1'b1;
                txLast_nxt  = 1'b0;
                state_nxt   = ST_SEND;
            end
            ST_SEND: begin
                if (txReady) begin
                    crc_nxt = crc8(crc_r, txByte_r);
                    if (txLast_r) begin
                        txValid_nxt = 1'b0;
                        txLast_nxt  = 1'b0;
                        state_nxt   = ST_IDLE;
                    end else if (idxInc == len_r) begin
                        idx_nxt    = idxInc;
                        txByte_nxt = crc_nxt;                  // PEC closes the block, see R7
                        txLast_nxt = 1'b1;
                    end else begin
                        idx_nxt    = idxInc;
                        txByte_nxt = buf_r[idxInc];
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r   <= ST_IDLE;
            chSel_r   <= 1'b0;
            idx_r     <= '0;
            len_r     <= '0;
            cmd_r     <= '0;
            crc_r     <= '0;
            buf_r     <= '{default: 8'h00};
            txByte_r  <= '0;
            txValid_r <= 1'b0;
            txLast_r  <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            chSel_r   <= chSel_nxt;
            idx_r     <= idx_nxt;
            len_r     <= len_nxt;
            cmd_r     <= cmd_nxt;
            crc_r     <= crc_nxt;
            buf_r     <= buf_nxt;
            txByte_r  <= txByte_nxt;
            txValid_r <= txValid_nxt;
            txLast_r  <= txLast_nxt;
            refused_r <= refused_nxt;
        end
    end

    assign txByte    = txByte_r;
    assign txValid   = txValid_r;
    assign txLast    = txLast_r;
    assign rdRefused = refused_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_energy_req;
        state_r == ST_IDLE && rdStart && (rdCmd == `PEA_CMD_EIN || rdCmd == `PEA_CMD_EOUT);
    endsequence
    sequence s_count_byte;
        state_r == ST_LOAD ##1 txValid && txByte == `PEA_EN_COUNT && !txLast;
    endsequence
    a_energy_frame: assert property (s_energy_req |=> s_count_byte) // see R17
        else $error("energy read did not open with byte count six");
    a_coef_frame: assert property (state_r == ST_IDLE && rdStart && rdCmd == `PEA_CMD_COEF
                                   ##2 txReady |=> txByte == COEF_M[7:0]) // see R6
        else $error("coefficient m low byte wrong");
    a_refuse_unk: assert property (state_r == ST_IDLE && rdStart && !isEnergy && rdCmd != `PEA_CMD_COEF
                                   |=> rdRefused && state_r == ST_IDLE)
        else $error("unknown command not refused");
    a_pec_end: assert property (txLast && txReady |=> !txValid && state_r == ST_IDLE) // see R7
        else $error("frame did not end after the PEC");
    a_out_period: assert property (outEnd |=> outCyc_r == '0 ##1 outCyc_r == 1) // see R5
        else $error("output window did not restart");
    a_in_bound: assert property (inCyc_r <= IN_LAST) // see R4
        else $error("input window reached 100 ms");
    a_stby_zero: assert property (stS2_r |-> smp[1] == '0) // see R15
        else $error("output power not zero in standby");
endmodule : pea_accumulator

// ===== dv/pea_host_model.sv
`timescale 1ns/1ps
module pea_host_model (
    input  wire logic       clock,   // System clock
    input  wire logic       nrst,    // Async reset, active low
    input  wire logic       slow,    // Stall between bytes
    input  wire logic [7:0] txByte,  // Byte offered
    input  wire logic       txValid, // Byte valid
    input  wire logic       txLast,  // PEC byte marker
    output logic            txReady  // Byte taken
);
    logic [7:0] rx[$];
    logic       lastFlag[$];
    int         frames;
    // Collect block-read bytes; a frame closes on its PEC byte
    initial begin
        txReady = 1'b0;
        frames = 0;
        forever begin
            @(posedge clock);
            if (nrst && txValid && txReady) begin
                rx.push_back(txByte);
                lastFlag.push_back(txLast);
                if (txLast) frames++;
            end
            #1 txReady = slow ? 1'($urandom_range(1, 0)) : 1'b1;
        end
    end
endmodule : pea_host_model

// ===== dv/tb_power_energy_accumulator.sv
`timescale 1ns/1ps
`include "pea_cfg.svh"
module tb_power_energy_accumulator;
    import pea_pkg::*;
    localparam int         OUT_CYC = 160;
    localparam int         IN_CYC  = 640;
    localparam logic [6:0] ADDR    = 7'h10; // Arbitrary bus address
    localparam logic [7:0] COEF[6] = '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic                  clock, nrst, acZeroCross, standby, rdStart, txReady;
    logic                  txValid, txLast, rdRefused, slow, acRun, rolled;
    logic [14:0]           inPower, outPower;
    pea_byte_type          rdCmd;
    logic [7:0]            txByte, fb[$];
    logic [22:0]           tot[2], tot0[2];
    logic [23:0]           cnt[2], cnt0[2];
    int                    errors, n_compared, cyc, nRef, acHalf = 25, t[2], t0[2];

    pea_accumulator #(.OUT_WIN_CYC(OUT_CYC), .IN_MAX_CYC(IN_CYC), .DEV_ADDR(ADDR)) DUT (
        .clock(clock), .nrst(nrst), .acZeroCross(acZeroCross), .standby(standby),
        .inPower(inPower), .outPower(outPower), .rdStart(rdStart), .rdCmd(rdCmd),
        .txReady(txReady), .txByte(txByte), .txValid(txValid), .txLast(txLast), .rdRefused(rdRefused));
    pea_host_model HOST (.clock(clock), .nrst(nrst), .slow(slow), .txByte(txByte),
        .txValid(txValid), .txLast(txLast), .txReady(txReady));

    // Clock, cycle count and refusal pulse count
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        nRef <= nRef + int'(rdRefused === 1'b1);
    end
    // Line-cycle pulses; four full cycles last 8*acHalf clocks
    initial begin
        acZeroCross = 1'b0;
        forever begin
            repeat (acHalf) @(posedge clock);
            #1 acZeroCross = acRun & ~acZeroCross;
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_byte
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_word
    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        return c;
    endfunction : crc8

    // One read; poke sends a second request while the frame is running
    task automatic read_frame(input pea_byte_type cmd, input int len, input logic poke);
        logic [7:0] c;
        int         f, k;
        f = HOST.frames + 1;
        HOST.rx.delete();
        HOST.lastFlag.delete();
        @(posedge clock);
        #1 rdStart = 1'b1;
        rdCmd = cmd;
        @(posedge clock);
        #1 rdStart = 1'b0;
        rdCmd = 8'($urandom);
        if (poke) begin
            repeat (3) @(posedge clock);
            #1 rdStart = 1'b1;
            rdCmd = `PEA_CMD_COEF;
            @(posedge clock);
            #1 rdStart = 1'b0;
        end
        for (k = 0; k < (len ? 2000 : 30) && HOST.frames < f; k++) @(posedge clock);
        repeat (poke ? 20 : 1) @(posedge clock);
        #1 fb = HOST.rx;
        check_word(32'(fb.size()), 32'(len), "frame length");
        c = crc8(crc8(crc8(8'h00, {ADDR, 1'b0}), cmd), {ADDR, 1'b1});
        if (len > 0 && fb.size() == len) begin
            for (k = 0; k < len - 1; k++) c = crc8(c, fb[k]);
            check_byte(fb[len-1], c, "pec");
            check_byte({7'h0, HOST.lastFlag[len-1]}, 8'h01, "pec marker");
        end
    endtask : read_frame

    // Energy read and decode of the snapshot of channel ch
    task automatic energy(input int ch);
        read_frame(ch ? `PEA_CMD_EOUT : `PEA_CMD_EIN, 8, 1'b0);
        tot0[ch] = tot[ch];
        cnt0[ch] = cnt[ch];
        t0[ch] = t[ch];
        t[ch] = cyc;
        if (fb.size() == 8) begin
            check_byte(fb[0], `PEA_EN_COUNT, "byte count");
            check_byte(fb[2] & 8'h80, 8'h00, "accum top bit");
            tot[ch] = {fb[3], fb[2][6:0], fb[1]};
            cnt[ch] = {fb[6], fb[5], fb[4]};
        end
    endtask : energy

    // Host arithmetic: growth equals samples times power, rate from elapsed time
    task automatic check_delta(input int ch, input logic [14:0] p, input int per);
        logic [47:0] prod;
        int          dc, el;
        dc = int'(cnt[ch] - cnt0[ch]);
        el = (t[ch] - t0[ch]) / per;
        prod = 48'(cnt[ch] - cnt0[ch]) * p;
        check_word(32'(23'(tot[ch] - tot0[ch])), 32'(prod[22:0]), "accum step");
        check_word(32'(dc >= el - 1 && dc <= el + 1), 32'd1, "sample rate");
    endtask : check_delta

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog well beyond the expected run of about 60000 cycles
    initial begin
        #900000;
        errors++;
        $display("unexpected at %0t: run timed out", $time);
        complete_run();
    end

    // Main sequence
    initial begin
        int k;
        nrst = 1'b0;
        standby = 1'b0;
        rdStart = 1'b0;
        rdCmd = 8'h00;
        slow = 1'b0;
        acRun = 1'b0;
        rolled = 1'b0;
        inPower = 15'h0;
        outPower = 15'h0;
        void'($urandom(90));
        repeat (2) @(posedge clock);
        #1 nrst = 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            energy(ch);
            check_word(32'(tot[ch]), 32'd0, "reset accum");
            check_word(32'(cnt[ch]), 32'd0, "reset count");
        end
        $display("test reset done");
        read_frame(`PEA_CMD_COEF, 7, 1'b0);
        foreach (COEF[i]) check_byte(fb[i], COEF[i], "coefficient");
        $display("test coefficients done");
        repeat (3) begin
            k = nRef;
            read_frame(8'h40 + 8'($urandom_range(15, 0)), 0, 1'b0);
            check_word(32'(nRef - k), 32'd1, "refusal pulse");
        end
        $display("test refusal done");
        inPower = 15'($urandom);
        outPower = 15'($urandom);
        acHalf = 20 + $urandom_range(10, 0);
        acRun = 1'b1;
        repeat (2 * IN_CYC) @(posedge clock);
        energy(0);
        energy(1);
        repeat (4) begin
            slow = 1'($urandom);
            repeat ($urandom_range(900, 300)) @(posedge clock);
            energy(0);
            energy(1);
            check_delta(0, inPower, 8 * acHalf);
            check_delta(1, outPower, OUT_CYC);
        end
        $display("test steady power done");
        acRun = 1'b0;
        repeat (2 * IN_CYC) @(posedge clock);
        energy(0);
        repeat (3 * IN_CYC) @(posedge clock);
        energy(0);
        check_delta(0, inPower, IN_CYC);
        $display("test no line cycles done");
        standby = 1'b1;
        repeat (2 * OUT_CYC) @(posedge clock);
        energy(1);
        repeat (4 * OUT_CYC) @(posedge clock);
        energy(1);
        check_delta(1, 15'h0, OUT_CYC);
        standby = 1'b0;
        $display("test standby done");
        outPower = 15'h7000 | 15'($urandom_range(4095, 0));
        repeat (2 * OUT_CYC) @(posedge clock);
        energy(1);
        repeat (10) begin
            repeat (30 * OUT_CYC) @(posedge clock);
            energy(1);
            check_delta(1, outPower, OUT_CYC);
            if (tot[1][22:15] < tot0[1][22:15]) rolled = 1'b1;
        end
        check_word(32'(rolled), 32'd1, "wrap rollover");
        $display("test wrap done");
        slow = 1'b1;
        read_frame(`PEA_CMD_EIN, 8, 1'b1);
        $display("test busy request done");
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1 nrst = 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            energy(ch);
            check_word(32'(tot[ch]), 32'd0, "reset accum");
            check_word(32'(cnt[ch]), 32'd0, "reset count");
        end
        $display("test second reset done");
        complete_run();
    end
endmodule : tb_power_energy_accumulator
